// ===== fsw_latch_ram.sv
// Row of write latches held as a small memory with registered read data
`timescale 1ns/1ps
module fsw_latch_ram #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);

    logic [WIDTH-1:0] mem_r [DEPTH];

    initial
    begin
        if (DEPTH > (1 << AW))
        begin
            $error("fsw_latch_ram: depth exceeds address range");
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_o <= '0;
        end
        else
        begin
            rdata_o <= mem_r[raddr_i];
        end
    end

endmodule

// ===== fsw_pkg.sv
// Shared constants, register map and state types of the flash self-write block
package fsw_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int WORD_W = 14;
    localparam int ROW_WORDS = 32;
    localparam int IDX_W = 5;
    localparam int ADDR_W = 15;
    localparam logic [IDX_W-1:0] LAST_IDX = 5'h1F;
    localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3FFF;
    localparam logic [1:0] NOP_CYCLES = 2'h2;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] OFS_DATA_LOW = 5'h00;
    localparam logic [4:0] OFS_DATA_HIGH = 5'h04;
    localparam logic [4:0] OFS_ADDR_LOW = 5'h08;
    localparam logic [4:0] OFS_ADDR_HIGH = 5'h0C;
    localparam logic [4:0] OFS_CONTROL = 5'h10;
    localparam logic [4:0] OFS_UNLOCK = 5'h14;

    // ----------------------------------------------------------------
    // Control register fields and reset values
    // ----------------------------------------------------------------
    localparam int BIT_CONFIG_SPACE_SELECT = 6;
    localparam int BIT_LATCH_ONLY_SELECT = 5;
    localparam int BIT_FREE = 4;
    localparam int BIT_WRERR = 3;
    localparam int BIT_PROGRAM_ENABLE_BIT = 2;
    localparam int BIT_WR = 1;
    localparam int BIT_RD = 0;
    localparam logic [7:0] ADDR_LOW_RST = 8'h00;
    localparam logic [6:0] ADDR_HIGH_RST = 7'h00;
    localparam logic [7:0] DATA_LOW_RST = 8'h00;
    localparam logic [5:0] DATA_HIGH_RST = 6'h00;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // ----------------------------------------------------------------
    // Configuration space map (low address bits, bit 15 implied)
    // ----------------------------------------------------------------
    localparam logic [14:0] CFG_UID_FIRST = 15'h0000;
    localparam logic [14:0] CFG_UID_LAST = 15'h0003;
    localparam logic [14:0] CFG_DEVID_FIRST = 15'h0005;
    localparam logic [14:0] CFG_CONF_LAST = 15'h0009;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_NOP = 3'h1,
        ST_STREAM = 3'h2,
        ST_COMMIT = 3'h3,
        ST_WAIT = 3'h4,
        ST_RD1 = 3'h5,
        ST_RD2 = 3'h6
    } fsw_st_t;

    typedef struct packed {
        fsw_st_t st;
        logic [7:0] dat_lo;
        logic [5:0] dat_hi;
        logic [7:0] adr_lo;
        logic [6:0] adr_hi;
        logic config_space_select;
        logic latch_only_select;
        logic free;
        logic wrerr;
        logic program_enable_bit;
        logic wr;
        logic rd;
        logic key55;
        logic armed;
        logic [1:0] nop_cnt;
        logic [IDX_W-1:0] idx;
        logic strm_v;
        logic sel_valid;
        logic [ROW_WORDS-1:0] valid;
        logic ack;
        logic [31:0] rdata;
        logic flash_rd;
        logic prog;
        logic erase;
        logic skip;
        logic [ADDR_W-1:0] faddr;
    } fsw_state_t;

endpackage

// ===== fsw_top.sv
// Flash self-write access logic: registers, unlock, write latches, row program
`timescale 1ns/1ps
// How it works
// - Latch-only set: unlock plus start loads one latch, two forced no-ops, no stall.
// - Latch-only clear: start programs all latches at once, stalls until write ends.
// - Row of 32 latches picked by address bits 4:0; 0x1F is the last.
// - Config select one steers reads and writes to ID and configuration region.
// - Config read outside accessible ranges clears both data registers to zero.
// - User IDs read/write; device IDs and configuration words are read only.
// - After read start one instruction runs, the next is skipped, data then ready.
// - Data high holds word bits 13:8 low; top two bits read zero.
// - Data low holds bits 7:0, read/write, kept on non-power resets.
// - Address low holds bits 7:0, read/write, cleared on every reset.
// - Every row program or erase end returns all latches to blank.
// - Start bit set only by software and cleared by hardware at completion.
// - Program enable clear before the start write inhibits every program and erase cycle.
module fsw_top #(
    parameter int ROW_WORDS = 32
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic SYS_RESET_I,
    input wire logic [4:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    output logic [14:0] FLASH_ADDR_O,
    output logic FLASH_CFG_O,
    output logic FLASH_RD_O,
    input wire logic [13:0] FLASH_RDATA_I,
    output logic FLASH_WE_O,
    output logic [13:0] FLASH_WDATA_O,
    output logic FLASH_PROG_O,
    output logic FLASH_ERASE_O,
    input wire logic FLASH_DONE_I,
    output logic CPU_STALL_O,
    output logic FORCE_NOP_O,
    output logic RD_SKIP_O
);

    fsw_pkg::fsw_state_t s_r;
    fsw_pkg::fsw_state_t s_nxt;
    logic [fsw_pkg::WORD_W-1:0] ram_rdata;
    logic ram_we;
    logic [fsw_pkg::IDX_W-1:0] ram_raddr;
    logic [fsw_pkg::ADDR_W-1:0] full_addr;

    initial
    begin
        if (ROW_WORDS != fsw_pkg::ROW_WORDS)
        begin
            $error("fsw_top: row size must match the latch row");
        end
    end

    // ----------------------------------------------------------------
    // Address decoding of the configuration region
    // ----------------------------------------------------------------
    function automatic logic cfg_readable(input logic [14:0] a);
        cfg_readable = (a <= fsw_pkg::CFG_UID_LAST) ||
            ((a >= fsw_pkg::CFG_DEVID_FIRST) && (a <= fsw_pkg::CFG_CONF_LAST));
    endfunction

    function automatic logic cfg_writable(input logic [14:0] a);
        cfg_writable = (a >= fsw_pkg::CFG_UID_FIRST) && (a <= fsw_pkg::CFG_UID_LAST);
    endfunction

    assign full_addr = {s_r.adr_hi, s_r.adr_lo};

    // ----------------------------------------------------------------
    // Write latch row
    // ----------------------------------------------------------------
    fsw_latch_ram #(
        .WIDTH(fsw_pkg::WORD_W),
        .DEPTH(fsw_pkg::ROW_WORDS),
        .AW(fsw_pkg::IDX_W)
    ) u_latches (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .we_i(ram_we),
        .waddr_i(s_r.adr_lo[fsw_pkg::IDX_W-1:0]),
        .wdata_i({s_r.dat_hi, s_r.dat_lo}),
        .raddr_i(ram_raddr),
        .rdata_o(ram_rdata)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic bus_wr;
        logic [7:0] wd;
        logic start_ok;
        logic cfg_block;
        bus_wr = 1'b0;
        wd = 8'h00;
        start_ok = 1'b0;
        cfg_block = 1'b0;
        s_nxt = s_r;
        ram_we = 1'b0;
        ram_raddr = s_r.idx;
        s_nxt.flash_rd = 1'b0;
        s_nxt.prog = 1'b0;
        s_nxt.erase = 1'b0;
        s_nxt.skip = 1'b0;
        s_nxt.strm_v = 1'b0;

        // Bus: one wait cycle, then the access completes
        s_nxt.ack = (AVS_READ_I || AVS_WRITE_I) && !s_r.ack;
        bus_wr = s_r.ack && AVS_WRITE_I && AVS_BYTEENABLE_I[0];
        wd = AVS_WRITEDATA_I[7:0];
        if ((AVS_READ_I || AVS_WRITE_I) && !s_r.ack)
        begin
            case (AVS_ADDRESS_I)
                fsw_pkg::OFS_DATA_LOW: s_nxt.rdata = {24'h000000, s_r.dat_lo};
                fsw_pkg::OFS_DATA_HIGH: s_nxt.rdata = {26'h0, s_r.dat_hi};
                fsw_pkg::OFS_ADDR_LOW: s_nxt.rdata = {24'h000000, s_r.adr_lo};
                fsw_pkg::OFS_ADDR_HIGH: s_nxt.rdata = {24'h000000, 1'b1, s_r.adr_hi};
                fsw_pkg::OFS_CONTROL: s_nxt.rdata = {24'h000000, 1'b1, s_r.config_space_select, s_r.latch_only_select,
                    s_r.free, s_r.wrerr, s_r.program_enable_bit, s_r.wr, s_r.rd};
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end

        if (bus_wr)
        begin
            if (AVS_ADDRESS_I != fsw_pkg::OFS_UNLOCK)
            begin
                s_nxt.key55 = 1'b0;
                s_nxt.armed = 1'b0;
            end
            case (AVS_ADDRESS_I)
                fsw_pkg::OFS_DATA_LOW: s_nxt.dat_lo = wd;
                fsw_pkg::OFS_DATA_HIGH: s_nxt.dat_hi = wd[5:0];
                fsw_pkg::OFS_ADDR_LOW: s_nxt.adr_lo = wd;
                fsw_pkg::OFS_ADDR_HIGH: s_nxt.adr_hi = wd[6:0];
                fsw_pkg::OFS_UNLOCK:
                begin
                    s_nxt.key55 = (wd == fsw_pkg::KEY_FIRST);
                    s_nxt.armed = s_r.key55 && (wd == fsw_pkg::KEY_SECOND);
                end
                fsw_pkg::OFS_CONTROL:
                begin
                    s_nxt.config_space_select = wd[fsw_pkg::BIT_CONFIG_SPACE_SELECT];
                    s_nxt.latch_only_select = wd[fsw_pkg::BIT_LATCH_ONLY_SELECT];
                    s_nxt.program_enable_bit = wd[fsw_pkg::BIT_PROGRAM_ENABLE_BIT];
                    s_nxt.wrerr = wd[fsw_pkg::BIT_WRERR];
                    if (s_r.st == fsw_pkg::ST_IDLE)
                    begin
                        s_nxt.free = wd[fsw_pkg::BIT_FREE];
                    end
                    if (wd[fsw_pkg::BIT_WR] && !s_r.wr)
                    begin
                        start_ok = s_r.armed && s_r.program_enable_bit && (s_r.st == fsw_pkg::ST_IDLE);
                        s_nxt.wrerr = !start_ok;
                    end
                    if (wd[fsw_pkg::BIT_RD] && !s_r.rd && !s_r.wr &&
                        (s_r.st == fsw_pkg::ST_IDLE))
                    begin
                        s_nxt.rd = 1'b1;
                        s_nxt.st = fsw_pkg::ST_RD1;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Accepted start: load the addressed latch unless erasing or the config address is not writable
        if (start_ok)
        begin
            s_nxt.wr = 1'b1;
            s_nxt.free = wd[fsw_pkg::BIT_FREE];
            cfg_block = wd[fsw_pkg::BIT_CONFIG_SPACE_SELECT] && !cfg_writable(full_addr);
            if (!wd[fsw_pkg::BIT_FREE] && !cfg_block)
            begin
                ram_we = 1'b1;
                s_nxt.valid[s_r.adr_lo[fsw_pkg::IDX_W-1:0]] = 1'b1;
            end
            s_nxt.nop_cnt = 2'h0;
            s_nxt.st = fsw_pkg::ST_NOP;
        end

        // ----------------------------------------------------------------
        // Sequencer
        // ----------------------------------------------------------------
        case (s_r.st)
            fsw_pkg::ST_IDLE:
            begin
            end
            fsw_pkg::ST_NOP:
            begin
                s_nxt.nop_cnt = s_r.nop_cnt + 2'h1;
                if (s_r.nop_cnt == fsw_pkg::NOP_CYCLES - 2'h1)
                begin
                    s_nxt.idx = '0;
                    if (s_r.config_space_select && !cfg_writable(full_addr))
                    begin
                        s_nxt.wr = 1'b0;
                        s_nxt.valid = '0;
                        s_nxt.st = fsw_pkg::ST_IDLE;
                    end
                    else if (s_r.free)
                    begin
                        s_nxt.erase = 1'b1;
                        s_nxt.faddr = full_addr;
                        s_nxt.st = fsw_pkg::ST_WAIT;
                    end
                    else if (s_r.latch_only_select)
                    begin
                        s_nxt.wr = 1'b0;
                        s_nxt.st = fsw_pkg::ST_IDLE;
                    end
                    else
                    begin
                        s_nxt.st = fsw_pkg::ST_STREAM;
                    end
                end
            end
            fsw_pkg::ST_STREAM:
            begin
                s_nxt.strm_v = 1'b1;
                s_nxt.sel_valid = s_r.valid[s_r.idx];
                s_nxt.faddr = {s_r.adr_hi, s_r.adr_lo[7:fsw_pkg::IDX_W], s_r.idx};
                s_nxt.idx = s_r.idx + 5'h01;
                if (s_r.idx == fsw_pkg::LAST_IDX)
                begin
                    s_nxt.st = fsw_pkg::ST_COMMIT;
                end
            end
            fsw_pkg::ST_COMMIT:
            begin
                s_nxt.prog = 1'b1;
                s_nxt.st = fsw_pkg::ST_WAIT;
            end
            fsw_pkg::ST_WAIT:
            begin
                if (FLASH_DONE_I)
                begin
                    s_nxt.wr = 1'b0;
                    s_nxt.free = 1'b0;
                    s_nxt.valid = '0;
                    s_nxt.st = fsw_pkg::ST_IDLE;
                end
            end
            fsw_pkg::ST_RD1:
            begin
                if (s_r.config_space_select && !cfg_readable(full_addr))
                begin
                    s_nxt.dat_lo = 8'h00;
                    s_nxt.dat_hi = 6'h00;
                    s_nxt.rd = 1'b0;
                    s_nxt.skip = 1'b1;
                    s_nxt.st = fsw_pkg::ST_IDLE;
                end
                else
                begin
                    s_nxt.flash_rd = 1'b1;
                    s_nxt.faddr = full_addr;
                    s_nxt.st = fsw_pkg::ST_RD2;
                end
            end
            fsw_pkg::ST_RD2:
            begin
                s_nxt.dat_lo = FLASH_RDATA_I[7:0];
                s_nxt.dat_hi = FLASH_RDATA_I[13:8];
                s_nxt.rd = 1'b0;
                s_nxt.skip = 1'b1;
                s_nxt.st = fsw_pkg::ST_IDLE;
            end
            default:
            begin
                s_nxt.st = fsw_pkg::ST_IDLE;
            end
        endcase

        // Non-power reset: control (except WRERR) and address clear, data kept
        if (SYS_RESET_I)
        begin
            s_nxt.st = fsw_pkg::ST_IDLE;
            s_nxt.adr_lo = fsw_pkg::ADDR_LOW_RST;
            s_nxt.adr_hi = fsw_pkg::ADDR_HIGH_RST;
            s_nxt.config_space_select = 1'b0;
            s_nxt.latch_only_select = 1'b0;
            s_nxt.free = 1'b0;
            s_nxt.program_enable_bit = 1'b0;
            s_nxt.wr = 1'b0;
            s_nxt.rd = 1'b0;
            s_nxt.key55 = 1'b0;
            s_nxt.armed = 1'b0;
            s_nxt.valid = '0;
            s_nxt.prog = 1'b0;
            s_nxt.erase = 1'b0;
            s_nxt.flash_rd = 1'b0;
            s_nxt.skip = 1'b0;
            s_nxt.strm_v = 1'b0;
            ram_we = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            s_r <= '0;
            s_r.st <= fsw_pkg::ST_IDLE;
            s_r.dat_lo <= fsw_pkg::DATA_LOW_RST;
            s_r.dat_hi <= fsw_pkg::DATA_HIGH_RST;
            s_r.adr_lo <= fsw_pkg::ADDR_LOW_RST;
            s_r.adr_hi <= fsw_pkg::ADDR_HIGH_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign AVS_READDATA_O = s_r.rdata;
    assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !s_r.ack;
    assign FLASH_ADDR_O = s_r.faddr;
    assign FLASH_CFG_O = s_r.config_space_select;
    assign FLASH_RD_O = s_r.flash_rd;
    assign FLASH_WE_O = s_r.strm_v;
    assign FLASH_WDATA_O = s_r.sel_valid ? ram_rdata : fsw_pkg::BLANK_WORD;
    assign FLASH_PROG_O = s_r.prog;
    assign FLASH_ERASE_O = s_r.erase;
    assign FORCE_NOP_O = (s_r.st == fsw_pkg::ST_NOP);
    assign CPU_STALL_O = (s_r.st == fsw_pkg::ST_STREAM) || (s_r.st == fsw_pkg::ST_COMMIT) ||
        (s_r.st == fsw_pkg::ST_WAIT);
    assign RD_SKIP_O = s_r.skip;

endmodule

// ===== fsw_top_properties.sv
// Concurrent property checker for the flash self-write block
`timescale 1ns/1ps
module fsw_top_props #(
    parameter int ROW_WORDS = 32
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic SYS_RESET_I,
    input wire logic [4:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic [14:0] FLASH_ADDR_O,
    input wire logic FLASH_CFG_O,
    input wire logic FLASH_RD_O,
    input wire logic [13:0] FLASH_RDATA_I,
    input wire logic FLASH_WE_O,
    input wire logic [13:0] FLASH_WDATA_O,
    input wire logic FLASH_PROG_O,
    input wire logic FLASH_ERASE_O,
    input wire logic FLASH_DONE_I,
    input wire logic CPU_STALL_O,
    input wire logic FORCE_NOP_O,
    input wire logic RD_SKIP_O
);
    // ------------
    // Properties
    // ------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    a_wait_first: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |->
        AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O) else $error("wait cycle count wrong");
    a_nop_two: assert property ($rose(FORCE_NOP_O) |-> FORCE_NOP_O[*2] ##1 !FORCE_NOP_O)
        else $error("forced no-op length wrong");
    a_done_ends: assert property (CPU_STALL_O && FLASH_DONE_I |=> !CPU_STALL_O)
        else $error("stall held after done");
    a_stream_stalled: assert property (FLASH_WE_O |-> CPU_STALL_O)
        else $error("latch stream without stall");
    a_prog_pulse: assert property (FLASH_PROG_O |-> CPU_STALL_O ##1 !FLASH_PROG_O)
        else $error("commit pulse wrong");
    a_erase_pulse: assert property (FLASH_ERASE_O |-> CPU_STALL_O ##1 !FLASH_ERASE_O)
        else $error("erase pulse wrong");
    a_read_skip: assert property (FLASH_RD_O |=> RD_SKIP_O && !FLASH_RD_O)
        else $error("read skip missing");
    a_high_top: assert property (AVS_READ_I && !AVS_WAITREQUEST_O &&
        AVS_ADDRESS_I == fsw_pkg::OFS_DATA_HIGH |-> AVS_READDATA_O[31:6] == 26'h0)
        else $error("data high top bits set");

    c_prog: cover property (FLASH_PROG_O);
    c_erase: cover property (FLASH_ERASE_O);
    c_cfg_read: cover property (RD_SKIP_O && FLASH_CFG_O);
endmodule

bind fsw_top fsw_top_props #(.ROW_WORDS(ROW_WORDS)) i_props (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .SYS_RESET_I(SYS_RESET_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .FLASH_ADDR_O(FLASH_ADDR_O), .FLASH_CFG_O(FLASH_CFG_O), .FLASH_RD_O(FLASH_RD_O),
    .FLASH_RDATA_I(FLASH_RDATA_I), .FLASH_WE_O(FLASH_WE_O), .FLASH_WDATA_O(FLASH_WDATA_O),
    .FLASH_PROG_O(FLASH_PROG_O), .FLASH_ERASE_O(FLASH_ERASE_O), .FLASH_DONE_I(FLASH_DONE_I),
    .CPU_STALL_O(CPU_STALL_O), .FORCE_NOP_O(FORCE_NOP_O), .RD_SKIP_O(RD_SKIP_O)
);

// ===== fsw_top_test.sv
// Self-checking register-level bench for the flash self-write block
`timescale 1ns/1ps
module fsw_top_test;
    logic clk = 1'b0, rstn = 1'b0, sys_rst = 1'b0, rd = 1'b0, wr = 1'b0, done = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic wreq, cfg, frd, fwe, prog, ers, stall, nop, skip, last_cfg, prog_cfg;
    logic [14:0] fadr;
    logic [13:0] fwd;
    logic [13:0] img [32];
    int num_errors = 0, n_compared = 0, we_cnt = 0, prog_cnt = 0, ers_cnt = 0;
    int rd_cnt = 0, bad_row = 0, nop_cyc = 0, skip_cnt = 0;

    always #2 clk = ~clk;

    fsw_top i_dut (
        .CLK_I(clk), .RESETN_I(rstn), .SYS_RESET_I(sys_rst), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hF),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .FLASH_ADDR_O(fadr),
        .FLASH_CFG_O(cfg), .FLASH_RD_O(frd), .FLASH_RDATA_I(14'h2B3C), .FLASH_WE_O(fwe),
        .FLASH_WDATA_O(fwd), .FLASH_PROG_O(prog), .FLASH_ERASE_O(ers), .FLASH_DONE_I(done),
        .CPU_STALL_O(stall), .FORCE_NOP_O(nop), .RD_SKIP_O(skip)
    );

    // ------------
    // Flash side monitor
    // ------------
    always @(posedge clk)
    begin
        if (fwe)
        begin
            img[fadr[4:0]] <= fwd;
            we_cnt <= we_cnt + 1;
            if (fadr[14:5] !== 10'h008)
                bad_row <= bad_row + 1;
        end
        if (frd)
            last_cfg <= cfg;
        if (prog)
            prog_cfg <= cfg;
        nop_cyc <= nop_cyc + int'(nop);
        skip_cnt <= skip_cnt + int'(skip);
        prog_cnt <= prog_cnt + int'(prog);
        ers_cnt <= ers_cnt + int'(ers);
        rd_cnt <= rd_cnt + int'(frd);
    end

    // ------------
    // Tasks
    // ------------
    task automatic complete_run();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            num_errors++;
            complete_run();
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic await(ref int cnt, input int tgt);
        int n;
        n = 0;
        while (cnt < tgt && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 200)
        begin
            num_errors++;
            complete_run();
        end
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    function automatic logic [13:0] wd(input int i);
        return {6'h2A, 8'h10 + 8'(i)};
    endfunction

    task automatic start(input logic [7:0] ctl);
        bus(1'b1, 5'h14, 8'h55);
        bus(1'b1, 5'h14, 8'hAA);
        bus(1'b1, 5'h10, ctl);
        repeat (3) @(posedge clk);
    endtask

    task automatic put(input logic [7:0] a, input logic [7:0] ctl);
        logic [13:0] w;
        w = wd(a);
        bus(1'b1, 5'h00, w[7:0]);
        bus(1'b1, 5'h04, {2'h0, w[13:8]});
        bus(1'b1, 5'h08, a);
        start(ctl);
    endtask

    task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        check(nm, exp, q);
    endtask

    task automatic row_check(input logic [31:0] mask, input int we_exp);
        check("stream count", we_exp, we_cnt);
        check("row select", 32'h0, bad_row);
        for (int i = 0; i < 32; i++)
            check("latch word", mask[i] ? {18'h0, wd(i)} : 32'h3FFF, {18'h0, img[i]});
        check("stall after done", 32'h0, {31'h0, stall});
        rd_chk("control after write", 5'h10, 32'h84);
    endtask

    // ------------
    // Main sequence
    // ------------
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd_chk("addr low reset", 5'h08, 32'h0);
        rd_chk("data high reset", 5'h04, 32'h0);
        rd_chk("control reset", 5'h10, 32'h80);
        bus(1'b1, 5'h00, 8'hA5);
        bus(1'b1, 5'h04, 8'hFF);
        bus(1'b1, 5'h08, 8'h5A);
        bus(1'b1, 5'h18, 8'h77);
        rd_chk("data low", 5'h00, 32'hA5);
        rd_chk("data high", 5'h04, 32'h3F);
        rd_chk("addr low", 5'h08, 32'h5A);
        rd_chk("unmapped", 5'h18, 32'h0);
        rd_chk("key reads zero", 5'h14, 32'h0);
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk("addr low sys reset", 5'h08, 32'h0);
        rd_chk("data low kept", 5'h00, 32'hA5);
        bus(1'b1, 5'h0C, 8'h01);
        bus(1'b1, 5'h10, 8'h24);
        for (int i = 0; i < 4; i++)
            put(8'(i), 8'h26);
        check("no stream on load", 32'h0, we_cnt);
        check("forced no-ops", 32'h8, nop_cyc);
        rd_chk("control after load", 5'h10, 32'hA4);
        bus(1'b1, 5'h10, 8'h04);
        put(8'h1F, 8'h06);
        await(prog_cnt, 1);
        row_check(32'h8000000F, 32);
        put(8'h03, 8'h06);
        await(prog_cnt, 2);
        row_check(32'h00000008, 64);
        bus(1'b1, 5'h10, 8'h06);
        repeat (3) @(posedge clk);
        rd_chk("start without key", 5'h10, 32'h8C);
        bus(1'b1, 5'h10, 8'h00);
        start(8'h02);
        repeat (40) @(posedge clk);
        rd_chk("start disabled", 5'h10, 32'h88);
        check("nothing programmed", 32'h2, prog_cnt);
        bus(1'b1, 5'h10, 8'h14);
        start(8'h16);
        await(ers_cnt, 1);
        rd_chk("control after erase", 5'h10, 32'h84);
        bus(1'b1, 5'h0C, 8'h00);
        bus(1'b1, 5'h08, 8'h05);
        bus(1'b1, 5'h10, 8'h01);
        repeat (3) @(posedge clk);
        rd_chk("read low", 5'h00, 32'h3C);
        check("read skip", 32'h1, skip_cnt);
        rd_chk("read high", 5'h04, 32'h2B);
        bus(1'b1, 5'h08, 8'h07);
        bus(1'b1, 5'h10, 8'h41);
        repeat (3) @(posedge clk);
        check("cfg read issued", 32'h2, rd_cnt);
        check("cfg select", 32'h1, {31'h0, last_cfg});
        bus(1'b1, 5'h08, 8'h04);
        bus(1'b1, 5'h10, 8'h41);
        repeat (3) @(posedge clk);
        rd_chk("cfg hole low", 5'h00, 32'h0);
        rd_chk("cfg hole high", 5'h04, 32'h0);
        check("cfg hole no read", 32'h2, rd_cnt);
        bus(1'b1, 5'h10, 8'h44);
        put(8'h07, 8'h46);
        repeat (40) @(posedge clk);
        check("read-only not written", 32'h2, prog_cnt);
        put(8'h02, 8'h46);
        await(prog_cnt, 3);
        check("user id written", 32'h1, {31'h0, prog_cfg});
        check("user id word", {18'h0, wd(2)}, {18'h0, img[2]});
        complete_run();
    end
endmodule
